/* src/msc_regs.sv */
`timescale 1ns/1ps
module msc_regs (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csn_b,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic restart_entry,
   input wire logic overtemp_event,
   input wire logic main_overvoltage,
   input wire logic failure_event,
   input wire logic failure_flag_clear,
   output logic [1:0] mode_request,
   output logic soft_reset_pulse,
   output logic reset_output_pin,
   output logic third_regulator_enable,
   output logic [1:0] second_regulator_mode,
   output logic main_overvoltage_flag,
   output logic overvoltage_restart_req,
   output logic [1:0] main_reset_threshold_sel,
   output logic third_regulator_voltage_sel,
   output logic failure_output_pins,
   output logic third_reg_undervolt_keep,
   output logic third_reg_load_share,
   output logic load_share_stop_enable,
   output logic wd_first_fail_cfg
);
   import msc_pkg::*;
   logic [6:0] addr;
   logic cmd_write, frame_done, addr_valid;
   logic [7:0] wr_data, rd_data;
   logic [7:0] mode_reg, next_mode_reg;
   logic [7:0] hw_reg, next_hw_reg;
   logic ov_flag, next_ov_flag;
   logic fail_latch, next_fail_latch;
   logic soft_rst, next_soft_rst;
   logic ro_out, next_ro_out;

   msc_serial_slave u_slave (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .sclk(sclk),
      .csn_b(csn_b),
      .sdi(sdi),
      .rd_data(rd_data),
      .sdo(sdo),
      .sdo_oe(sdo_oe),
      .addr(addr),
      .cmd_write(cmd_write),
      .wr_data(wr_data),
      .frame_done(frame_done),
      .addr_valid(addr_valid)
   );

   // read mux; sampled at address time so a write shows the old value
   always_comb begin
      unique case (addr)
         MSC_ADDR_MODE: rd_data = mode_reg;
         MSC_ADDR_HW: rd_data = hw_reg & MSC_HW_WMASK;
         default: rd_data = 8'h00;
      endcase
   end

   // register updates: serial writes, then hardware overrides
   always_comb begin
      next_mode_reg = mode_reg;
      next_hw_reg = hw_reg;
      next_soft_rst = 1'b0;
      if (frame_done && cmd_write && addr == MSC_ADDR_MODE) begin
         next_mode_reg = wr_data;
         // stop to sleep is refused, mode kept
         if (mode_reg[MSC_MODE_HI:MSC_MODE_LO] == MSC_MODE_STOP
               && wr_data[MSC_MODE_HI:MSC_MODE_LO] == MSC_MODE_SLEEP) begin
            next_mode_reg[MSC_MODE_HI:MSC_MODE_LO] = MSC_MODE_STOP;
         end
         if (wr_data[MSC_MODE_HI:MSC_MODE_LO] == MSC_MODE_SOFTRST) begin
            next_soft_rst = 1'b1;
         end
      end
      if (frame_done && cmd_write && addr == MSC_ADDR_HW) begin
         next_hw_reg = wr_data & MSC_HW_WMASK;
      end
      // soft reset: clear all but voltage select and load share
      if (soft_rst) begin
         next_mode_reg = MSC_MODE_RST;
         next_hw_reg = hw_reg & MSC_HW_KEEP_SOFT;
      end
      if (overtemp_event) begin
         next_mode_reg[MSC_V2_HI:MSC_V2_LO] = MSC_V2_OFF;
      end
      if (restart_entry) begin
         next_mode_reg[MSC_MODE_HI:MSC_MODE_LO] = MSC_MODE_NORMAL;
         next_mode_reg[MSC_V2_HI:MSC_V2_LO] = MSC_V2_OFF;
         next_hw_reg[MSC_HW_FO_FORCE] = 1'b0;
      end
   end

   // status and pin logic; event set wins over clear
   always_comb begin
      next_ov_flag = ov_flag | main_overvoltage;
      next_fail_latch = fail_latch;
      if (failure_flag_clear) begin
         next_fail_latch = 1'b0;
      end
      if (failure_event) begin
         next_fail_latch = 1'b1;
      end
      // reset output pulled low during soft reset unless suppressed
      next_ro_out = ~(soft_rst & ~hw_reg[MSC_HW_SR_SUP]);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mode_reg <= MSC_MODE_RST;
         hw_reg <= MSC_HW_RST;
         ov_flag <= 1'b0;
         fail_latch <= 1'b0;
         soft_rst <= 1'b0;
         ro_out <= 1'b1;
      end else begin
         mode_reg <= next_mode_reg;
         hw_reg <= next_hw_reg;
         ov_flag <= next_ov_flag;
         fail_latch <= next_fail_latch;
         soft_rst <= next_soft_rst;
         ro_out <= next_ro_out;
      end
   end

   // registered field outputs
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mode_request <= 2'h0;
         soft_reset_pulse <= 1'b0;
         reset_output_pin <= 1'b1;
         third_regulator_enable <= 1'b0;
         second_regulator_mode <= 2'h0;
         main_overvoltage_flag <= 1'b0;
         overvoltage_restart_req <= 1'b0;
         main_reset_threshold_sel <= 2'h0;
         third_regulator_voltage_sel <= 1'b0;
         failure_output_pins <= 1'b0;
         third_reg_undervolt_keep <= 1'b0;
         third_reg_load_share <= 1'b0;
         load_share_stop_enable <= 1'b0;
         wd_first_fail_cfg <= 1'b0;
      end else begin
         mode_request <= mode_reg[MSC_MODE_HI:MSC_MODE_LO];
         soft_reset_pulse <= soft_rst;
         reset_output_pin <= ro_out;
         third_regulator_enable <= mode_reg[MSC_V3_ON];
         second_regulator_mode <= mode_reg[MSC_V2_HI:MSC_V2_LO];
         main_overvoltage_flag <= ov_flag;
         overvoltage_restart_req <= main_overvoltage & mode_reg[MSC_OV_REACT];
         main_reset_threshold_sel <= mode_reg[1:0];
         third_regulator_voltage_sel <= hw_reg[MSC_HW_V3_VSEL];
         failure_output_pins <= hw_reg[MSC_HW_FO_FORCE] | fail_latch;
         third_reg_undervolt_keep <= hw_reg[MSC_HW_UV_KEEP];
         third_reg_load_share <= hw_reg[MSC_HW_LS];
         load_share_stop_enable <= hw_reg[MSC_HW_LS_STP];
         wd_first_fail_cfg <= hw_reg[MSC_HW_WD_CFG];
      end
   end

   // checks
   stop_sleep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      mode_reg[7:6] == 2'h2 && !restart_entry && !soft_rst |=> mode_reg[7:6] != 2'h1)
      else $error("stop went to sleep");
   restart_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      restart_entry |=> mode_reg[7:6] == 2'h0 ##1 mode_request == 2'h0)
      else $error("restart did not set normal");
   v2_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      restart_entry || overtemp_event |=> ##1 second_regulator_mode == 2'h0)
      else $error("second regulator not off");
   rsvd_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      hw_reg[2] == 1'b0)
      else $error("reserved bit set");
   soft_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      soft_rst && !restart_entry |=> hw_reg == ($past(hw_reg) & 8'h88))
      else $error("soft reset config wrong");
   ro_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      soft_rst && !hw_reg[6] |=> ##1 !reset_output_pin)
      else $error("reset output not pulled");
   fo_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      restart_entry |=> !hw_reg[5])
      else $error("force bit not cleared");
   fail_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      failure_event |=> ##1 failure_output_pins)
      else $error("failure output not active");
   ov_req_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      main_overvoltage && !mode_reg[2] |=> !overvoltage_restart_req)
      else $error("overvoltage restart while disabled");
   wr_mode_c: cover property (@(posedge core_clk) frame_done && cmd_write && addr == 7'h01);
   wr_hw_c: cover property (@(posedge core_clk) frame_done && cmd_write && addr == 7'h02);
   soft_c: cover property (@(posedge core_clk) soft_rst);
   rd_c: cover property (@(posedge core_clk) frame_done && !cmd_write);
endmodule

/* src/msc_pkg.sv */
package msc_pkg;
   // register indices on the serial bus (7-bit address)
   localparam logic [6:0] MSC_ADDR_MODE = 7'h01;
   localparam logic [6:0] MSC_ADDR_HW = 7'h02;
   // field positions, mode/supply register
   localparam int MSC_MODE_HI = 7;
   localparam int MSC_MODE_LO = 6;
   localparam int MSC_V3_ON = 5;
   localparam int MSC_V2_HI = 4;
   localparam int MSC_V2_LO = 3;
   localparam int MSC_OV_REACT = 2;
   // field positions, hardware config register
   localparam int MSC_HW_V3_VSEL = 7;
   localparam int MSC_HW_SR_SUP = 6;
   localparam int MSC_HW_FO_FORCE = 5;
   localparam int MSC_HW_UV_KEEP = 4;
   localparam int MSC_HW_LS = 3;
   localparam int MSC_HW_RSVD = 2;
   localparam int MSC_HW_LS_STP = 1;
   localparam int MSC_HW_WD_CFG = 0;
   // reset values and masks
   localparam logic [7:0] MSC_MODE_RST = 8'h00;
   localparam logic [7:0] MSC_HW_RST = 8'h00;
   localparam logic [7:0] MSC_HW_KEEP_SOFT = 8'h88;
   localparam logic [7:0] MSC_HW_WMASK = 8'hFB;
   // command frame
   localparam int MSC_FRAME_BITS = 16;
   localparam int MSC_WR_BIT = 7;
   // mode encodings
   typedef enum logic [1:0] {
      MSC_MODE_NORMAL = 2'h0,
      MSC_MODE_SLEEP = 2'h1,
      MSC_MODE_STOP = 2'h2,
      MSC_MODE_SOFTRST = 2'h3
   } msc_mode_e;
   localparam logic [1:0] MSC_V2_OFF = 2'h0;
endpackage

/* src/msc_serial_slave.sv */
`timescale 1ns/1ps
// 16-bit shift slave: sclk and csn sampled by core_clk, data on rising edge,
// output shifted on falling edge, msb first
module msc_serial_slave (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic csn_b,
   input wire logic sdi,
   input wire logic [7:0] rd_data,
   output logic sdo,
   output logic sdo_oe,
   output logic [6:0] addr,
   output logic cmd_write,
   output logic [7:0] wr_data,
   output logic frame_done,
   output logic addr_valid
);
   import msc_pkg::*;
   logic [2:0] s1, s2;
   logic sclk_q, csn_q;
   logic [15:0] shreg, next_shreg;
   logic [4:0] cnt, next_cnt;
   logic [7:0] tx, next_tx;
   logic next_sdo, next_done, next_av;
   logic [6:0] next_addr;
   logic next_wr;
   logic load_q, next_load;
   wire rise = s2[0] & ~sclk_q;
   wire fall = ~s2[0] & sclk_q;
   // two-flop synchronisers, first stage read only by second
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s1 <= 3'h2;
         s2 <= 3'h2;
      end else begin
         s1 <= {sdi, csn_b, sclk};
         s2 <= s1;
      end
   end
   // shift and count; answer byte loaded once address is known
   always_comb begin
      next_shreg = shreg;
      next_cnt = cnt;
      next_tx = tx;
      next_sdo = sdo;
      next_done = 1'b0;
      next_av = addr_valid;
      next_addr = addr;
      next_wr = cmd_write;
      if (s2[1]) begin
         next_cnt = 5'h00;
         next_av = 1'b0;
         if (!csn_q && cnt == 5'(MSC_FRAME_BITS)) begin
            next_done = 1'b1;
         end
      end else if (rise && cnt < 5'(MSC_FRAME_BITS)) begin
         next_shreg = {shreg[14:0], s2[2]};
         next_cnt = cnt + 5'h01;
         if (cnt == 5'h07) begin
            next_addr = shreg[6:0];
            next_wr = s2[2];
            next_av = 1'b1;
         end
      end else if (fall && addr_valid && cnt >= 5'h08) begin
         next_sdo = tx[7];
         next_tx = {tx[6:0], 1'b0};
      end
      if (addr_valid && !next_av) begin
         next_sdo = 1'b0;
      end
      // addr port is registered, so the read mux shows the new register a cycle later
      next_load = next_av & ~addr_valid;
      if (load_q) begin
         next_tx = rd_data;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         shreg <= 16'h0000;
         cnt <= 5'h00;
         tx <= 8'h00;
         sdo <= 1'b0;
         frame_done <= 1'b0;
         addr_valid <= 1'b0;
         addr <= 7'h00;
         cmd_write <= 1'b0;
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
         sdo_oe <= 1'b0;
         load_q <= 1'b0;
      end else begin
         shreg <= next_shreg;
         cnt <= next_cnt;
         tx <= next_tx;
         sdo <= next_sdo;
         frame_done <= next_done;
         addr_valid <= next_av;
         addr <= next_addr;
         cmd_write <= next_wr;
         sclk_q <= s2[0];
         csn_q <= s2[1];
         sdo_oe <= ~s2[1];
         load_q <= next_load;
      end
   end
   assign wr_data = shreg[7:0];
endmodule

/* testbench/msc_host_model.sv */
`timescale 1ns/1ps
// serial host: sclk idles low and stands still between frames
module msc_host_model (
   input wire logic core_clk,
   output logic sclk,
   output logic csn_b,
   output logic sdi,
   input wire logic sdo,
   output logic [7:0] rd_byte,
   output logic rd_valid
);
   initial begin
      sclk = 1'b0;
      csn_b = 1'b1;
      sdi = 1'b0;
      rd_byte = 8'h00;
      rd_valid = 1'b0;
   end
   // one whole frame, msb first; half period of 6 cycles gives 24 ns
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
      logic [15:0] f;
      f = {a, w, d};
      @(posedge core_clk);
      csn_b <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi <= f[i];
         repeat (6) @(posedge core_clk);
         if (i < 8) rd_byte[i] = sdo; // data phase carries the old value
         sclk <= 1'b1;
         repeat (6) @(posedge core_clk);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge core_clk);
      // released line shows the inverse, not a stale bit
      sdi <= ~sdi;
      csn_b <= 1'b1;
      rd_valid <= 1'b1;
      @(posedge core_clk);
      rd_valid <= 1'b0;
      // csn_b high long enough for commit and field update
      repeat (8) @(posedge core_clk);
   endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   import msc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] ev = 5'h00;
   logic sclk, csn_b, sdi, sdo, sdo_oe, rd_valid, srp, rop, v3en, ovf, ovr;
   logic v3sel, fop, uvk, lsh, lss, wdc;
   logic [1:0] mreq, v2m, rts;
   logic [7:0] rd_byte, exp_b, d, mr, h;
   logic [7:0] exp_q[$];
   int errors = 0;
   int n_checks = 0;
   int n_low = 0;
   int n_sr = 0;
   int n_oe = 0;
   int c0, c1;
   initial forever #2 core_clk = ~core_clk;
   msc_regs msc_regs_i (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .csn_b(csn_b),
      .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .restart_entry(ev[0]), .overtemp_event(ev[1]),
      .main_overvoltage(ev[2]), .failure_event(ev[3]), .failure_flag_clear(ev[4]),
      .mode_request(mreq), .soft_reset_pulse(srp), .reset_output_pin(rop),
      .third_regulator_enable(v3en), .second_regulator_mode(v2m),
      .main_overvoltage_flag(ovf), .overvoltage_restart_req(ovr),
      .main_reset_threshold_sel(rts), .third_regulator_voltage_sel(v3sel),
      .failure_output_pins(fop), .third_reg_undervolt_keep(uvk),
      .third_reg_load_share(lsh), .load_share_stop_enable(lss), .wd_first_fail_cfg(wdc));
   msc_host_model msc_host_model_i (.core_clk(core_clk), .sclk(sclk), .csn_b(csn_b),
      .sdi(sdi), .sdo(sdo), .rd_byte(rd_byte), .rd_valid(rd_valid));
   // scoreboard: each finished frame consumes the oldest note
   always @(posedge core_clk) begin
      if (rd_valid === 1'b1) begin
         exp_b = exp_q.pop_front();
         `CHK("serial byte", exp_b, rd_byte)
      end
      if (rop === 1'b0) n_low++;
      if (srp === 1'b1) n_sr++;
      if (sdo_oe === 1'b1) n_oe++;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] v, input logic [7:0] old);
      exp_q.push_back(old);
      msc_host_model_i.xfer(a, 1'b1, v);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      msc_host_model_i.xfer(a, 1'b0, 8'h00);
   endtask
   // one-cycle event pulse, then wait for the falling edge after it ends
   task automatic pulse(input int k);
      @(posedge core_clk);
      ev[k] <= 1'b1;
      @(posedge core_clk);
      ev[k] <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
   initial begin
      c0 = $urandom(32'h4502b34b);
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(MSC_ADDR_MODE, MSC_MODE_RST);
      rd(MSC_ADDR_HW, MSC_HW_RST);
      `CHK("sdo idle", 1'b0, sdo_oe)
      `CHK("sdo driven", 1'b1, n_oe > 0)
      // unmapped address: reads zero, write ignored
      wr(7'h05, 8'h5A, 8'h00);
      rd(7'h05, 8'h00);
      d = $urandom();
      wr(MSC_ADDR_HW, d, 8'h00);
      h = d & MSC_HW_WMASK;
      rd(MSC_ADDR_HW, h);
      `CHK("v3 voltage", d[7], v3sel)
      `CHK("fo pins", d[5], fop)
      `CHK("uv keep", d[4], uvk)
      `CHK("load share", d[3], lsh)
      `CHK("ls stop", d[1], lss)
      `CHK("wd cfg", d[0], wdc)
      mr = 8'h00;
      for (int m = 0; m < 3; m++) begin
         d = $urandom();
         d = {m[1:0], d[5:3], 1'b0, d[1:0]};
         wr(MSC_ADDR_MODE, d, mr);
         mr = d;
         `CHK("mode", d[7:6], mreq)
         `CHK("v3 on", d[5], v3en)
         `CHK("v2 mode", d[4:3], v2m)
         `CHK("threshold", d[1:0], rts)
      end
      // sleep request from stop is refused
      wr(MSC_ADDR_MODE, {2'h1, mr[5:0]}, mr);
      `CHK("no stop to sleep", MSC_MODE_STOP, mreq)
      pulse(2);
      `CHK("ov no restart", 1'b0, ovr)
      // flag output sits one stage behind the sticky flag
      @(negedge core_clk);
      `CHK("ov flag", 1'b1, ovf)
      wr(MSC_ADDR_MODE, mr | 8'h04, mr);
      mr = mr | 8'h04;
      pulse(2);
      `CHK("ov restart", 1'b1, ovr)
      // restart request stands only while overvoltage is present
      @(negedge core_clk);
      `CHK("ov restart ends", 1'b0, ovr)
      `CHK("ov flag kept", 1'b1, ovf)
      wr(MSC_ADDR_MODE, {2'h2, mr[5], 2'h3, 1'b0, mr[1:0]}, mr);
      mr = {2'h2, mr[5], 2'h3, 1'b0, mr[1:0]};
      wr(MSC_ADDR_HW, 8'hA8, h);
      h = 8'h88;
      `CHK("fo forced", 1'b1, fop)
      pulse(0);
      repeat (3) @(negedge core_clk);
      `CHK("restart mode", MSC_MODE_NORMAL, mreq)
      `CHK("restart v2", MSC_V2_OFF, v2m)
      `CHK("restart fo", 1'b0, fop)
      mr = mr & 8'h23;
      rd(MSC_ADDR_MODE, mr);
      rd(MSC_ADDR_HW, h);
      wr(MSC_ADDR_MODE, mr | 8'h18, mr);
      pulse(1);
      repeat (3) @(negedge core_clk);
      `CHK("overtemp v2", MSC_V2_OFF, v2m)
      pulse(3);
      repeat (3) @(negedge core_clk);
      wr(MSC_ADDR_HW, h | 8'h20, h);
      wr(MSC_ADDR_HW, h, h | 8'h20);
      `CHK("fo event held", 1'b1, fop)
      pulse(4);
      repeat (3) @(negedge core_clk);
      `CHK("fo released", 1'b0, fop)
      // soft reset with reset pin pulled, then with it suppressed
      c0 = n_low;
      c1 = n_sr;
      wr(MSC_ADDR_MODE, mr | 8'hC0, mr);
      `CHK("pin pulled", 1, n_low - c0)
      `CHK("soft reset", 1, n_sr - c1)
      rd(MSC_ADDR_MODE, MSC_MODE_RST);
      rd(MSC_ADDR_HW, MSC_HW_KEEP_SOFT);
      wr(MSC_ADDR_HW, 8'h40, MSC_HW_KEEP_SOFT);
      c0 = n_low;
      wr(MSC_ADDR_MODE, 8'hC0, MSC_MODE_RST);
      `CHK("pin kept", 0, n_low - c0)
      rd(MSC_ADDR_HW, MSC_HW_RST);
      print_verdict();
   end
endmodule
